// File: src/adcsp_dev.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module adcsp_dev
  import adcsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  adcsp_if.dev             link,
  input  wire logic [11:0] result_data,
  output logic      [11:0] cfg_word,
  output logic      [3:0]  cmd_code,
  output logic             cmd_strobe,
  output logic             fifo_read,
  output logic             power_down,
  output logic      [10:0] input_select,
  output logic             first_result_invalid,
  output logic             word_strobe,
  output logic      [15:0] rx_word,
  output logic             iface_dsp
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: [0] select, [1] clock, [2] sync, [3] data in
  logic [3:0] pin_q;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  adcsp_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h5)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({link.sdi, link.frame_sync_strobe, link.sclk, link.cs_n}),
    .level    (pin_q),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  function automatic logic is_select(input logic [3:0] cmd);
    is_select = (cmd <= CMD_CH_LAST) || (cmd >= CMD_TST_MID && cmd <= CMD_TST_POS);
  endfunction

  function automatic logic [3:0] sel_index(input logic [3:0] cmd);
    sel_index = (cmd <= CMD_CH_LAST) ? cmd : cmd - TST_OFFSET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // frame control
  adcsp_dev_state_t st_reg;
  logic             dsp_reg;
  logic [4:0]       bit_cnt_reg;
  logic [15:0]      in_sr_reg;
  logic [15:0]      out_sr_reg;
  logic             oe_reg;
  logic             start;
  logic             cap;
  logic             chg;
  logic             last_cap;
  logic             cmd_cap;
  logic [3:0]       cmd_next;
  logic [15:0]      word_next;

  assign start = (st_reg == D_IDLE && !pin_q[0] && pin_q[2]) ||
                 ((st_reg == D_ARM || (st_reg == D_DONE && dsp_reg)) &&
                  !pin_q[0] && pin_fall[2]);
  assign cap = (st_reg == D_XFER) && (dsp_reg ? pin_fall[1] : pin_rise[1]);
  // no shift before the first capture: a leading rise in sync mode would skip the msb
  assign chg = (st_reg == D_XFER) && (bit_cnt_reg != 5'h00) &&
               (dsp_reg ? pin_rise[1] : pin_fall[1]);
  assign last_cap  = cap && (bit_cnt_reg == WORD_BITS - 5'h01);
  assign cmd_cap   = cap && (bit_cnt_reg == CMD_BITS - 5'h01);
  assign cmd_next  = {in_sr_reg[2:0], pin_q[3]};
  assign word_next = {in_sr_reg[14:0], pin_q[3]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= D_IDLE;
    end else if (pin_q[0]) begin
      st_reg <= D_IDLE;
    end else begin
      unique case (st_reg)
        D_IDLE: st_reg <= pin_q[2] ? D_XFER : D_ARM;
        D_ARM:  if (start) st_reg <= D_XFER;
        D_XFER: if (last_cap) st_reg <= D_DONE;
        D_DONE: if (start) st_reg <= D_XFER;
      endcase
    end
  end

  // sync level at the select fall fixes the edge scheme
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dsp_reg <= 1'b0;
    end else if (st_reg == D_IDLE && !pin_q[0]) begin
      dsp_reg <= !pin_q[2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 5'h00;
    end else if (start) begin
      bit_cnt_reg <= 5'h00;
    end else if (cap) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_sr_reg <= 16'h0000;
    end else if (cap) begin
      in_sr_reg <= word_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output shifter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_sr_reg <= 16'h0000;
    end else if (start) begin
      out_sr_reg <= {result_data, RES_PAD};
    end else if (cmd_cap && cmd_next == CMD_CFG_RD) begin
      // keep the bit on the pin, queue config behind it
      out_sr_reg <= {out_sr_reg[15], cfg_word, 3'h0};
    end else if (chg) begin
      out_sr_reg <= {out_sr_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_reg <= 1'b0;
    end else if (pin_q[0]) begin
      oe_reg <= 1'b0;
    end else if (start) begin
      oe_reg <= 1'b1;
    end else if (last_cap) begin
      oe_reg <= 1'b0;
    end
  end

  assign link.sdo_o  = out_sr_reg[15];
  assign link.sdo_oe = oe_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_code   <= 4'h0;
      cmd_strobe <= 1'b0;
      fifo_read  <= 1'b0;
    end else begin
      cmd_strobe <= cmd_cap;
      fifo_read  <= cmd_cap && cmd_next == CMD_FIFO_RD;
      if (cmd_cap) begin
        cmd_code <= cmd_next;
      end
    end
  end

  // trailing data goes to rx_word and is used only by a config write and the type-word match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_word    <= CFG_RESET;
      word_strobe <= 1'b0;
      rx_word     <= 16'h0000;
      iface_dsp   <= 1'b0;
    end else begin
      word_strobe <= last_cap;
      if (last_cap) begin
        rx_word <= word_next;
        if (cmd_code == CMD_CFG_WR) begin
          cfg_word <= word_next[11:0];
        end
        if (word_next == INIT_WORD) begin
          iface_dsp <= dsp_reg;
        end
      end
    end
  end

  // a fresh frame wakes the converter; its first result is then stale
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_down <= 1'b0;
    end else if (cmd_cap && cmd_next == CMD_PWRDN) begin
      power_down <= 1'b1;
    end else if (start) begin
      power_down <= 1'b0;
    end
  end

  logic first_conv_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_conv_reg       <= 1'b1;
      first_result_invalid <= 1'b0;
    end else if (start && power_down) begin
      first_conv_reg <= 1'b1;
    end else if (cmd_cap && is_select(cmd_next)) begin
      first_result_invalid <= first_conv_reg;
      first_conv_reg       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input selector
  adcsp_mux_state_t mux_st_reg;
  logic [3:0]       target_reg;
  logic [3:0]       bbm_cnt_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mux_st_reg   <= M_HOLD;
      target_reg   <= 4'h0;
      bbm_cnt_reg  <= 4'h0;
      input_select <= 11'h000;
    end else if (cmd_cap && is_select(cmd_next)) begin
      mux_st_reg   <= M_BREAK;
      target_reg   <= sel_index(cmd_next);
      bbm_cnt_reg  <= BBM_COUNT;
      input_select <= 11'h000;
    end else begin
      unique case (mux_st_reg)
        M_HOLD: ;
        M_BREAK: begin
          bbm_cnt_reg <= bbm_cnt_reg - 4'h1;
          if (bbm_cnt_reg == 4'h1) begin
            mux_st_reg   <= M_HOLD;
            input_select <= SEL_ONE << target_reg;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: src/adcsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_host
  import adcsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  adcsp_if.host            link,
  input  wire logic        use_sync_strobe,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [11:0] req_data,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_word,
  output logic      [11:0] rsp_data,
  output logic             rsp_stale
);
  logic sdo_q;

  adcsp_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_sdo_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (link.sdo_line),
    .level    (sdo_q),
    .rise     (),
    .fall     ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  adcsp_host_state_t st_reg;
  logic        init_pend_reg;
  logic        dsp_reg;
  logic        cs_n_reg;
  logic        sclk_reg;
  logic        strobe_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [4:0]  cap_cnt_reg;
  logic [3:0]  half_reg;
  logic        launch;
  logic        tick;
  logic        cap_e;
  logic        frame_end;

  assign launch = (st_reg == H_IDLE) && (init_pend_reg || (req_valid && req_ready));
  assign tick   = (st_reg != H_IDLE) && (half_reg == SCLK_HALF_LAST);
  assign cap_e  = dsp_reg ? sclk_reg : !sclk_reg;
  assign frame_end = sclk_reg && (dsp_reg ? cap_cnt_reg == WORD_BITS - 5'h01
                                          : cap_cnt_reg == WORD_BITS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_reg <= 4'h0;
    end else if (launch || tick) begin
      half_reg <= 4'h0;
    end else if (st_reg != H_IDLE) begin
      half_reg <= half_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg      <= H_IDLE;
      dsp_reg     <= 1'b0;
      cs_n_reg    <= 1'b1;
      sclk_reg    <= 1'b0;
      strobe_reg  <= 1'b1;
      tx_reg      <= 16'h0000;
      rx_reg      <= 16'h0000;
      cap_cnt_reg <= 5'h00;
    end else begin
      unique case (st_reg)
        H_IDLE: begin
          strobe_reg <= !use_sync_strobe;
          if (launch) begin
            st_reg      <= H_LEAD;
            dsp_reg     <= use_sync_strobe;
            cs_n_reg    <= 1'b0;
            cap_cnt_reg <= 5'h00;
            if (init_pend_reg) begin
              tx_reg <= INIT_WORD;
            end else begin
              // data field only matters for a config write
              tx_reg <= {req_cmd, (req_cmd == CMD_CFG_WR) ? req_data : 12'h000};
            end
          end
        end
        H_LEAD: if (tick) begin
          if (dsp_reg) begin
            strobe_reg <= 1'b1;
            st_reg <= H_SYNC;
          end else begin
            st_reg <= H_CLK;
          end
        end
        H_SYNC: if (tick) begin
          strobe_reg <= 1'b0;
          st_reg <= H_CLK;
        end
        H_CLK: if (tick) begin
          sclk_reg <= !sclk_reg;
          if (cap_e) begin
            rx_reg      <= {rx_reg[14:0], sdo_q};
            cap_cnt_reg <= cap_cnt_reg + 5'h01;
          end else if (cap_cnt_reg != 5'h00) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
          end
          if (frame_end) begin
            st_reg <= H_TAIL;
          end
        end
        H_TAIL: if (tick) begin
          cs_n_reg <= 1'b1;
          st_reg   <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n              = cs_n_reg;
  assign link.sclk              = sclk_reg;
  assign link.frame_sync_strobe = strobe_reg;
  assign link.sdi               = tx_reg[15];

  ////////////////////////////////////////////////////////////////////////////////
  // user side
  logic pend_first_reg;
  logic arm_stale_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready      <= 1'b0;
      init_pend_reg  <= 1'b1;
      rsp_valid      <= 1'b0;
      rsp_word       <= 16'h0000;
      rsp_data       <= 12'h000;
      rsp_stale      <= 1'b0;
      pend_first_reg <= 1'b1;
      arm_stale_reg  <= 1'b0;
    end else begin
      req_ready <= (st_reg == H_IDLE) && !launch && !init_pend_reg;
      rsp_valid <= (st_reg == H_TAIL) && tick;
      if (launch && !init_pend_reg) begin
        if (req_cmd == CMD_PWRDN) begin
          pend_first_reg <= 1'b1;
        end else if (req_cmd <= CMD_CH_LAST ||
                     (req_cmd >= CMD_TST_MID && req_cmd <= CMD_TST_POS)) begin
          arm_stale_reg  <= pend_first_reg;
          pend_first_reg <= 1'b0;
        end
      end
      if (st_reg == H_TAIL && tick) begin
        init_pend_reg <= 1'b0;
        rsp_word      <= rx_reg;
        rsp_data      <= rx_reg[11:0];
        rsp_stale     <= arm_stale_reg && !launch;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/adcsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcsp_if;
  logic cs_n;
  logic sclk;
  logic frame_sync_strobe;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  wire  sdo_line;

  // no pull on the line: released it shows the inverse, so a stray sample is caught
  assign sdo_line = sdo_oe ? sdo_o : !sdo_o;

  modport dev (
    input  cs_n,
    input  sclk,
    input  frame_sync_strobe,
    input  sdi,
    output sdo_o,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output frame_sync_strobe,
    output sdi,
    input  sdo_line
  );
endinterface
`default_nettype wire

// File: src/adcsp_pkg.sv
`default_nettype none
package adcsp_pkg;
  // frame layout
  localparam logic [4:0]  WORD_BITS   = 5'h10;
  localparam logic [4:0]  CMD_BITS    = 5'h04;
  localparam logic [3:0]  RES_PAD     = 4'h0;
  localparam logic [11:0] CFG_RESET   = 12'h000;
  localparam logic [15:0] INIT_WORD   = 16'ha000;
  localparam logic [10:0] SEL_ONE     = 11'h001;
  // command codes
  localparam logic [3:0]  CMD_CH_LAST = 4'h7;
  localparam logic [3:0]  CMD_PWRDN   = 4'h8;
  localparam logic [3:0]  CMD_CFG_RD  = 4'h9;
  localparam logic [3:0]  CMD_CFG_WR  = 4'ha;
  localparam logic [3:0]  CMD_TST_MID = 4'hb;
  localparam logic [3:0]  CMD_TST_POS = 4'hd;
  localparam logic [3:0]  CMD_FIFO_RD = 4'he;
  // test inputs follow the eight external ones in the selector
  localparam logic [3:0]  TST_OFFSET  = 4'h3;
  // timing
  localparam int          CLK_MHZ     = 200;
  localparam int          BBM_NS      = 20;
  localparam int          BBM_CYC     = (BBM_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  BBM_COUNT   = 4'(BBM_CYC);
  localparam int          SCLK_HALF_NS  = 40;
  localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [3:0]  SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_ARM  = 2'b01,
    D_XFER = 2'b10,
    D_DONE = 2'b11
  } adcsp_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_SYNC = 3'b010,
    H_CLK  = 3'b011,
    H_TAIL = 3'b100
  } adcsp_host_state_t;

  typedef enum logic {
    M_HOLD  = 1'b0,
    M_BREAK = 1'b1
  } adcsp_mux_state_t;
endpackage
`default_nettype wire

// File: src/adcsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
      prev_reg <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// File: tb/adcsp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_properties
  import adcsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic frame_sync_strobe,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic       sclk_q_reg;
  logic       strobe_q_reg;
  logic [4:0] fall_cnt_reg;
  logic       sclk_fell;
  logic       strobe_fell;

  assign sclk_fell   = sclk_q_reg && !sclk;
  assign strobe_fell = strobe_q_reg && !frame_sync_strobe;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_reg   <= 1'b0;
      strobe_q_reg <= 1'b1;
    end else begin
      sclk_q_reg   <= sclk;
      strobe_q_reg <= frame_sync_strobe;
    end
  end

  // falls cover both modes: spi drops output before its 16th fall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_cnt_reg <= 5'h00;
    end else if (cs_n || strobe_fell) begin
      fall_cnt_reg <= 5'h00;
    end else if (sclk_fell && fall_cnt_reg != 5'h10) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_float_idle: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("output driven while deselected");
  a_float_on_rise: assert property ($rose(cs_n) |-> ##[1:5] !sdo_oe)
    else $error("output not released after deselect");
  a_spi_first_bit: assert property ($fell(cs_n) && frame_sync_strobe |-> ##[1:6] sdo_oe)
    else $error("no msb after select in spi mode");
  a_dsp_wait_sync: assert property ($fell(cs_n) && !frame_sync_strobe |-> !sdo_oe [*8])
    else $error("output driven before sync in dsp mode");
  a_dsp_first_bit: assert property (strobe_fell && !cs_n |-> ##[1:6] sdo_oe)
    else $error("no msb after sync fall");
  a_spi_bit_stable: assert property (
    $rose(sclk) && frame_sync_strobe && sdo_oe |-> $stable(sdo_o) [*5])
    else $error("spi data moves near rising edge");
  a_dsp_bit_stable: assert property (
    $fell(sclk) && !frame_sync_strobe && sdo_oe |-> $stable(sdo_o) [*5])
    else $error("dsp data moves near falling edge");
  a_float_after_word: assert property (fall_cnt_reg == 5'h10 |-> ##[0:6] !sdo_oe)
    else $error("output still driven after sixteen edges");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcsp_pkg::*;
  logic        clk, sys_rst, use_sync_strobe, req_valid, req_ready, rsp_valid;
  logic        cmd_strobe, fifo_read, power_down, first_result_invalid;
  logic        word_strobe, iface_dsp, stale_exp, rsp_stale;
  logic [3:0]  req_cmd, cmd_code, cur_cmd;
  logic [11:0] req_data, result_data, cfg_word, rsp_data, cfg_exp;
  logic [15:0] rsp_word, rx_word, lfsr_reg;
  logic [10:0] input_select, last_sel;
  int          err_total, total_checks, gap, i;

  adcsp_if link();
  adcsp_dev adcsp_dev_inst(.clk(clk), .sys_rst(sys_rst), .link(link),
    .result_data(result_data), .cfg_word(cfg_word), .cmd_code(cmd_code),
    .cmd_strobe(cmd_strobe), .fifo_read(fifo_read), .power_down(power_down),
    .input_select(input_select), .first_result_invalid(first_result_invalid),
    .word_strobe(word_strobe), .rx_word(rx_word), .iface_dsp(iface_dsp));
  adcsp_host adcsp_host_inst(.clk(clk), .sys_rst(sys_rst), .link(link),
    .use_sync_strobe(use_sync_strobe), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_word(rsp_word), .rsp_data(rsp_data), .rsp_stale(rsp_stale));
  adcsp_properties adcsp_properties_inst(.clk(clk), .sys_rst(sys_rst),
    .cs_n(link.cs_n), .sclk(link.sclk), .frame_sync_strobe(link.frame_sync_strobe),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic is_sel(input logic [3:0] c);
    return c <= CMD_CH_LAST || (c >= CMD_TST_MID && c <= CMD_TST_POS);
  endfunction

  function automatic logic [10:0] sel_exp(input logic [3:0] c);
    return c <= CMD_CH_LAST ? SEL_ONE << c : SEL_ONE << (c - TST_OFFSET);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the host sends the type word by itself after every reset
  task automatic boot;
    int n;
    // the type word's own command decode is checked by the fifo monitor
    cur_cmd = INIT_WORD[15:12];
    for (n = 0; n < 2000 && !word_strobe; n++) @(posedge clk);
    check("init word", rx_word, INIT_WORD);
    check("iface", 16'(iface_dsp), 16'(use_sync_strobe));
    check("cfg reset", 16'(cfg_word), 16'(CFG_RESET));
  endtask

  task automatic xfer(input logic [3:0] c, input logic [11:0] d, input logic [11:0] res);
    int n;
    @(posedge clk);
    req_cmd     <= c;
    req_data    <= d;
    req_valid   <= 1'b1;
    result_data <= res;
    cur_cmd     = c;
    @(posedge clk);
    for (n = 0; n < 1000 && !req_ready; n++) @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 2000 && !rsp_valid; n++) @(posedge clk);
    check("response", 16'(rsp_valid), 16'h0001);
    check("rx word", rx_word, {c, c == CMD_CFG_WR ? d : 12'h000});
    check("cmd", 16'(cmd_code), 16'(c));
    check("pwrdn", 16'(power_down), 16'(c == CMD_PWRDN));
    if (c == CMD_CFG_RD) check("cfg read", 16'(rsp_data), 16'(cfg_exp));
    else check("result", 16'(rsp_word[15:4]), 16'(res));
    if (c == CMD_CFG_WR) cfg_exp = d;
    check("cfg", 16'(cfg_word), 16'(cfg_exp));
    if ({c, d} == INIT_WORD) check("iface", 16'(iface_dsp), 16'(use_sync_strobe));
    if (c == CMD_PWRDN) stale_exp = 1'b1;
    if (is_sel(c)) begin
      check("select", 16'(input_select), 16'(sel_exp(c)));
      check("invalid", 16'(first_result_invalid), 16'(stale_exp));
      check("stale", 16'(rsp_stale), 16'(stale_exp));
      stale_exp = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (cmd_strobe) check("fifo", 16'(fifo_read), 16'(cur_cmd == CMD_FIFO_RD));
    if (input_select != 11'h000) begin
      if (last_sel != 11'h000 && input_select != last_sel) begin
        check("break gap", 16'(gap >= BBM_CYC), 16'h0001);
      end
      check("one hot", 16'($countones(input_select)), 16'h0001);
      last_sel = input_select;
      gap = 0;
    end else begin
      gap++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // about 60 frames of some 300 cycles each
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    use_sync_strobe = 1'b0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_data = 12'h000;
    result_data = 12'h000;
    lfsr_reg = 16'h23e1;
    cfg_exp = 12'h000;
    stale_exp = 1'b1;
    last_sel = 11'h000;
    gap = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    boot();
    xfer(CMD_CFG_WR, 12'hfff, 12'h000);
    xfer(CMD_CFG_RD, 12'h000, 12'hfff);
    xfer(4'h0, 12'h000, 12'hfff);
    xfer(CMD_PWRDN, 12'h000, 12'h800);
    xfer(CMD_CH_LAST, 12'h000, 12'h001);
    for (i = 0; i < 48; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      // random idle gaps let the select line rest between frames
      repeat (lfsr_reg[3:0]) @(posedge clk);
      if (i % 12 == 6) begin
        use_sync_strobe <= ~use_sync_strobe;
        xfer(CMD_CFG_WR, 12'h000, lfsr_reg[11:0]);
      end
      if (i < 16) xfer(4'(i), lfsr_reg[11:0], lfsr_reg[15:4]);
      else xfer(lfsr_reg[15:12], lfsr_reg[11:0], lfsr_reg[13:2]);
    end
    // reset in mid-frame: a fresh type word must follow
    @(posedge clk);
    cur_cmd = 4'h3;
    req_cmd <= 4'h3;
    req_valid <= 1'b1;
    repeat (80) @(posedge clk);
    sys_rst <= 1'b1;
    req_valid <= 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    cfg_exp = 12'h000;
    stale_exp = 1'b1;
    boot();
    xfer(CMD_TST_POS, 12'h000, 12'h5a5);
    xfer(CMD_CFG_RD, 12'h000, 12'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
